// file: rtl/counter_compare_output_irq.sv
// Compare, output and interrupt stage of one counter channel.
// Assumes a counter core supplying the count and limit events, and an
// AHB-Lite master for configuration.
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
module counter_compare_output_irq
  import counter_compare_pkg::*;
#(
  parameter int channel_number    = HARDWARE_GATE_INPUT_CHANNEL,
  parameter int pulse_step_cycles = PULSE_STEP_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [31:0] count_value,
  input  wire logic        count_overflow,
  input  wire logic        count_underflow,
  input  wire logic        hardware_gate_input,
  output logic             channel_output,
  output logic             compare_status_flag,
  output logic             count_enable,
  output logic      [4:0]  process_irq_pulse,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [10:0] control_reg;
  logic [31:0] compare_reg;
  logic [7:0]  hysteresis_reg;
  logic [7:0]  pulse_len_reg;
  logic [4:0]  irq_enable_reg;
  logic [4:0]  irq_status_reg;
  logic [4:0]  irq_mask_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] prev_count_reg;
  logic        prev_at_cmp_reg;
  logic        cond_reg;
  logic        zero_hold_reg;
  logic        pulse_active_reg;
  logic [15:0] pre_cnt_reg;
  logic [7:0]  step_cnt_reg;
  logic [7:0]  pulse_len_q_reg;
  logic        gate_prev_reg;
  logic        gate_level;

  // Sign-extends a count so that offsets by the hysteresis cannot wrap.
  function automatic logic signed [33:0] widen(input logic [31:0] v);
    return {{2{v[31]}}, v};
  endfunction : widen

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        addr_phase;
  logic        addr_mapped;
  logic [31:0] read_mux;
  logic        wr_ctrl;
  logic        wr_cmp;
  logic        wr_hyst;
  logic        wr_len;
  logic        wr_ien;
  logic        wr_ists;
  logic        wr_imask;
  logic [31:0] state_word;

  // Zero wait states; unmapped addresses read zero and ignore writes.
  assign addr_phase  = hsel && htrans[1] && hready;
  assign addr_mapped = haddr[31:8] == 24'h00_0000;
  assign wr_ctrl  = wr_pend_reg && wr_addr_reg == ADDR_CONTROL;
  assign wr_cmp   = wr_pend_reg && wr_addr_reg == ADDR_COMPARE;
  assign wr_hyst  = wr_pend_reg && wr_addr_reg == ADDR_HYSTERESIS;
  assign wr_len   = wr_pend_reg && wr_addr_reg == ADDR_PULSE_LEN;
  assign wr_ien   = wr_pend_reg && wr_addr_reg == ADDR_IRQ_ENABLE;
  assign wr_ists  = wr_pend_reg && wr_addr_reg == ADDR_IRQ_STATUS;
  assign wr_imask = wr_pend_reg && wr_addr_reg == ADDR_IRQ_MASK;
  assign state_word = {27'h000_0000, count_enable, pulse_active_reg,
                       gate_level, channel_output, compare_status_flag};
  assign read_mux =
      !addr_mapped                   ? 32'h0000_0000
    : haddr[7:0] == ADDR_CONTROL    ? {21'h00_0000, control_reg}
    : haddr[7:0] == ADDR_COMPARE    ? compare_reg
    : haddr[7:0] == ADDR_HYSTERESIS ? {24'h00_0000, hysteresis_reg}
    : haddr[7:0] == ADDR_PULSE_LEN  ? {24'h00_0000, pulse_len_reg}
    : haddr[7:0] == ADDR_IRQ_ENABLE ? {27'h000_0000, irq_enable_reg}
    : haddr[7:0] == ADDR_IRQ_STATUS ? {27'h000_0000, irq_status_reg}
    : haddr[7:0] == ADDR_IRQ_MASK   ? {27'h000_0000, irq_mask_reg}
    : haddr[7:0] == ADDR_STATE      ? state_word
    : 32'h0000_0000;

  // Bus phase tracking and read data.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite && addr_mapped;
      wr_addr_reg <= haddr[7:0];
      hrdata      <= (addr_phase && !hwrite) ? read_mux : 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  // Configuration registers; interrupt sources start disabled.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      control_reg    <= CONTROL_RESET;
      compare_reg    <= COMPARE_RESET;
      hysteresis_reg <= BYTE_RESET;
      pulse_len_reg  <= BYTE_RESET;
      irq_enable_reg <= IRQ_RESET;
      irq_mask_reg   <= IRQ_RESET;
    end else begin
      if (wr_ctrl) control_reg <= hwdata[10:0];
      if (wr_cmp) compare_reg <= hwdata;
      if (wr_hyst) hysteresis_reg <= hwdata[7:0];
      if (wr_len) pulse_len_reg <= hwdata[7:0];
      if (wr_ien) irq_enable_reg <= hwdata[4:0];
      if (wr_imask) irq_mask_reg <= hwdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Control decode and gate
  // ----------------------------------------------------------------
  out_mode_type mode;
  main_dir_type main_dir;
  logic         is_none;
  logic         is_comp;
  logic         is_pulse;
  logic         software_gate_bit;
  logic         gate_ch;
  logic         gate_rise;
  logic         gate_fall;
  logic         count_enable_next;

  assign mode     = out_mode_type'(control_reg[CTL_MODE_LSB +: 2]);
  assign main_dir = main_dir_type'(control_reg[CTL_DIR_LSB +: 2]);
  assign is_none  = mode == MODE_NONE;
  assign is_comp  = mode == MODE_COMPARATOR;
  assign is_pulse = mode == MODE_PULSE;
  assign software_gate_bit  = control_reg[CTL_SWGATE_BIT];
  assign gate_ch  = channel_number == HARDWARE_GATE_INPUT_CHANNEL;

  // The gate input passes the same frequency limit as the count inputs.
  input_pulse_filter u_gate_filter (
    .clock      (clock),
    .nrst       (nrst),
    .raw_in     (hardware_gate_input),
    .min_cycles (filter_cycles(control_reg[CTL_FREQ_LSB +: 3])),
    .level_out  (gate_level)
  );

  // Gate edges count only on the gate channel with the software gate open.
  assign gate_rise = gate_ch && software_gate_bit && gate_level && !gate_prev_reg;
  assign gate_fall = gate_ch && software_gate_bit && !gate_level && gate_prev_reg;
  assign count_enable_next = software_gate_bit && (!(gate_ch
    && control_reg[CTL_HWGATE_BIT]) || gate_level);

  // ----------------------------------------------------------------
  // Comparator with hysteresis
  // ----------------------------------------------------------------
  logic signed [33:0] cnt_w;
  logic signed [33:0] cmp_w;
  logic signed [33:0] hyst_w;
  logic               raw_cond;
  logic               release_cond;
  logic               cond_next;
  logic               at_cmp;
  logic               reach_hit;
  logic               moved_up;
  logic               moved_down;
  logic               reach_ok;
  logic               zero_hold_next;

  assign cnt_w  = widen(count_value);
  assign cmp_w  = widen(compare_reg);
  assign hyst_w = (hysteresis_reg > HYST_OFF_MAX)
                ? {26'h000_0000, hysteresis_reg} : 34'sh0_0000_0000;
  assign raw_cond = control_reg[CTL_LE_BIT] ? cnt_w <= cmp_w
                                            : cnt_w >= cmp_w;
  // Once set, the condition holds until the count leaves the band.
  assign release_cond = control_reg[CTL_LE_BIT]
                      ? cnt_w > cmp_w + hyst_w : cnt_w < cmp_w - hyst_w;
  assign cond_next = is_comp && (cond_reg ? !release_cond : raw_cond);

  // Reaching the value is its first sample; direction from the step.
  assign at_cmp     = count_value == compare_reg;
  assign reach_hit  = at_cmp && !prev_at_cmp_reg;
  assign moved_up   = cnt_w > widen(prev_count_reg);
  assign moved_down = cnt_w < widen(prev_count_reg);
  assign reach_ok   = reach_hit && (main_dir == DIR_NONE
                    || (main_dir == DIR_UP && moved_up)
                    || (main_dir == DIR_DOWN && moved_down));
  assign zero_hold_next = is_pulse && pulse_len_reg == 8'h00
                        && at_cmp && (reach_ok || zero_hold_reg);

  // ----------------------------------------------------------------
  // Pulse timer
  // ----------------------------------------------------------------
  logic        pulse_start;
  logic        pre_last;
  logic        pulse_end;
  logic        pulse_active_next;
  logic [15:0] pre_cnt_next;
  logic [7:0]  step_cnt_next;
  logic [7:0]  pulse_len_q_next;

  // A running pulse is never restarted by a second reach.
  assign pulse_start = is_pulse && reach_ok && !pulse_active_reg
                     && pulse_len_reg != 8'h00;
  assign pre_last  = pre_cnt_reg == 16'(pulse_step_cycles - 1);
  assign pulse_end = pulse_active_reg && pre_last
                   && step_cnt_reg == pulse_len_q_reg - 8'h01;
  assign pulse_active_next = pulse_start || (pulse_active_reg && !pulse_end);
  assign pre_cnt_next  = (!pulse_active_reg || pre_last) ? 16'h0000
                       : pre_cnt_reg + 16'h0001;
  assign step_cnt_next = !pulse_active_reg ? 8'h00
                       : pre_last ? step_cnt_reg + 8'h01 : step_cnt_reg;
  assign pulse_len_q_next = pulse_start ? pulse_len_reg
                          : pulse_len_q_reg;

  // ----------------------------------------------------------------
  // Output, flag and interrupts
  // ----------------------------------------------------------------
  logic       out_next;
  logic       flag_next;
  logic       cmp_event;
  logic [4:0] irq_event;
  logic [4:0] irq_clear;
  logic [4:0] irq_status_next;

  assign out_next = is_none ? control_reg[CTL_MANUAL_BIT]
                  : is_comp ? cond_next
                  : is_pulse && (pulse_active_next || zero_hold_next);
  assign flag_next = !is_none && out_next;
  assign cmp_event = (is_comp && cond_next && !cond_reg)
                   || (is_pulse && reach_ok);
  assign irq_event = irq_enable_reg & {count_underflow,
                     count_overflow, cmp_event,
                     gate_fall, gate_rise};
  assign irq_clear = wr_ists ? hwdata[4:0] : 5'h00;
  // A new event wins over a clear in the same cycle.
  assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;

  // Comparator, pulse and output state.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_count_reg      <= 32'h0000_0000;
      prev_at_cmp_reg     <= 1'b0;
      cond_reg            <= 1'b0;
      zero_hold_reg       <= 1'b0;
      pulse_active_reg    <= 1'b0;
      pre_cnt_reg         <= 16'h0000;
      step_cnt_reg        <= 8'h00;
      pulse_len_q_reg     <= 8'h00;
      channel_output      <= 1'b0;
      compare_status_flag <= 1'b0;
    end else begin
      prev_count_reg      <= count_value;
      prev_at_cmp_reg     <= at_cmp;
      cond_reg            <= cond_next;
      zero_hold_reg       <= zero_hold_next;
      pulse_active_reg    <= pulse_active_next;
      pre_cnt_reg         <= pre_cnt_next;
      step_cnt_reg        <= step_cnt_next;
      pulse_len_q_reg     <= pulse_len_q_next;
      channel_output      <= out_next;
      compare_status_flag <= flag_next;
    end
  end

  // Gate history, count enable and interrupt outputs.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_prev_reg     <= 1'b0;
      count_enable      <= 1'b0;
      process_irq_pulse <= 5'h00;
      irq_status_reg    <= IRQ_RESET;
      irq               <= 1'b0;
    end else begin
      gate_prev_reg     <= gate_level;
      count_enable      <= count_enable_next;
      process_irq_pulse <= irq_event;
      irq_status_reg    <= irq_status_next;
      irq               <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_NONE_FLAG_CLEAR: assert property (
    is_none ##1 is_none |-> !compare_status_flag)
    else $error("Compare flag set with no comparison.");

  AST_COMPARE_LEVEL: assert property (
    is_comp && cond_next |=> channel_output && compare_status_flag)
    else $error("Comparator hit did not set output and flag.");

  AST_PULSE_STARTS: assert property (
    pulse_start |=> channel_output && pulse_active_reg)
    else $error("Pulse did not start on reaching the value.");

  AST_PULSE_HELD: assert property (
    pulse_active_reg && is_pulse |-> channel_output)
    else $error("Output dropped during a timed pulse.");

  AST_NO_RETRIGGER: assert property (
    pulse_active_reg && reach_ok && !pulse_end
      |=> step_cnt_reg >= $past(step_cnt_reg))
    else $error("Pulse restarted while running.");

  AST_LENGTH_FROZEN: assert property (
    pulse_active_reg && !pulse_end |=> $stable(pulse_len_q_reg))
    else $error("Pulse length changed during a pulse.");

  AST_ZERO_LEN_RELEASE: assert property (
    is_pulse && !pulse_active_reg && !at_cmp |=> !channel_output)
    else $error("Zero-length output held past the condition.");

  AST_HYST_HOLD: assert property (
    is_comp && cond_reg && !release_cond |=> cond_reg)
    else $error("Condition released inside the hysteresis band.");

  AST_GATE_OPEN_IRQ: assert property (
    gate_rise && irq_enable_reg[IRQ_GATE_OPEN]
      |=> process_irq_pulse[IRQ_GATE_OPEN] && irq_status_reg[IRQ_GATE_OPEN])
    else $error("Gate opening did not raise its interrupt.");

  AST_OVERFLOW_IRQ: assert property (
    count_overflow && irq_enable_reg[IRQ_OVERFLOW]
      |=> process_irq_pulse[IRQ_OVERFLOW])
    else $error("Overflow did not raise its interrupt.");

  AST_CMP_IRQ_ONE_CYCLE: assert property (
    process_irq_pulse[IRQ_COMPARE] |=> !process_irq_pulse[IRQ_COMPARE])
    else $error("Comparator request longer than one cycle.");

  AST_GATED_COUNT: assert property (
    ##1 count_enable == $past(count_enable_next))
    else $error("Count enable does not follow the gates.");

endmodule : counter_compare_output_irq

// file: rtl/counter_compare_pkg.sv
// Constants of the counter compare, output and interrupt stage.
// Assumes a 10 MHz module clock and word-wide AHB-Lite access.
package counter_compare_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_COMPARE    = 8'h04;
  localparam logic [7:0] ADDR_HYSTERESIS = 8'h08;
  localparam logic [7:0] ADDR_PULSE_LEN  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
  localparam logic [7:0] ADDR_STATE      = 8'h1c;
  localparam int CTL_MODE_LSB   = 0;
  localparam int CTL_LE_BIT     = 2;
  localparam int CTL_DIR_LSB    = 3;
  localparam int CTL_SWGATE_BIT = 5;
  localparam int CTL_HWGATE_BIT = 6;
  localparam int CTL_MANUAL_BIT = 7;
  localparam int CTL_FREQ_LSB   = 8;
  localparam logic [10:0] CONTROL_RESET = 11'h500;
  localparam logic [31:0] COMPARE_RESET = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [4:0]  IRQ_RESET     = 5'h00;
  localparam int IRQ_GATE_OPEN  = 0;
  localparam int IRQ_GATE_CLOSE = 1;
  localparam int IRQ_COMPARE    = 2;
  localparam int IRQ_OVERFLOW   = 3;
  localparam int IRQ_UNDERFLOW  = 4;
  localparam int HARDWARE_GATE_INPUT_CHANNEL = 3;
  localparam logic [7:0] HYST_OFF_MAX = 8'h01;

  typedef enum logic [1:0] {MODE_NONE, MODE_COMPARATOR, MODE_PULSE}
    out_mode_type;
  typedef enum logic [1:0] {DIR_NONE, DIR_UP, DIR_DOWN} main_dir_type;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ         = 10;
  localparam int PULSE_STEP_MS     = 2;
  localparam int PULSE_STEP_CYCLES = PULSE_STEP_MS * CLOCK_MHZ * 1000;
  localparam int FILT_NS_1K   = 400000;
  localparam int FILT_NS_2K   = 200000;
  localparam int FILT_NS_5K   = 80000;
  localparam int FILT_NS_10K  = 40000;
  localparam int FILT_NS_30K  = 13000;
  localparam int FILT_NS_60K  = 6700;
  localparam int FILT_NS_100K = 4000;

  // Least accepted pulse in cycles, rounded up.
  function automatic logic [11:0] ns_cycles(input int ns);
    return 12'((ns * CLOCK_MHZ + 999) / 1000);
  endfunction : ns_cycles

  // Maps the input frequency setting to its least pulse in cycles.
  function automatic logic [11:0] filter_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    return ns_cycles(FILT_NS_1K);
      3'h1:    return ns_cycles(FILT_NS_2K);
      3'h2:    return ns_cycles(FILT_NS_5K);
      3'h3:    return ns_cycles(FILT_NS_10K);
      3'h4:    return ns_cycles(FILT_NS_30K);
      3'h6:    return ns_cycles(FILT_NS_100K);
      default: return ns_cycles(FILT_NS_60K);
    endcase
  endfunction : filter_cycles

endpackage : counter_compare_pkg

// file: rtl/input_pulse_filter.sv
// Pulse filter for a field input: rejects pulses shorter than a limit.
// Assumes the raw input is synchronous to the module clock.
`timescale 1ns/10ps
module input_pulse_filter (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        raw_in,
  input  wire logic [11:0] min_cycles,
  output logic             level_out
);

  logic [11:0] stable_cnt_reg;
  logic [11:0] stable_cnt_next;
  logic        level_next;
  logic        differs;
  logic        long_enough;

  // The new level is taken once it has stood for the least pulse.
  assign differs         = raw_in != level_out;
  assign long_enough     = stable_cnt_reg >= min_cycles - 12'h001;
  assign level_next      = (differs && long_enough) ? raw_in : level_out;
  assign stable_cnt_next = (!differs || long_enough) ? 12'h000
                         : stable_cnt_reg + 12'h001;

  // Filter state.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stable_cnt_reg <= 12'h000;
      level_out      <= 1'b0;
    end else begin
      stable_cnt_reg <= stable_cnt_next;
      level_out      <= level_next;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  AST_SHORT_PULSE_REJECTED: assert property (
    $changed(level_out) |-> $past(raw_in) == level_out
      && $past(stable_cnt_reg) >= $past(min_cycles) - 12'h001)
    else $error("Filter passed a pulse below the least length.");

endmodule : input_pulse_filter

// file: tb/field_encoder_model.sv
// Field side model: counter core and gate pin seen by the compare stage.
// Assumes the bench gives load, step and gate commands after rising edges.
`timescale 1ns/10ps
module field_encoder_model #(
  parameter int hi = 100,
  parameter int lo = -100
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  input  wire logic        up,
  input  wire logic        down,
  input  wire logic        gate_cmd,
  output logic      [31:0] count_value,
  output logic             count_overflow,
  output logic             count_underflow,
  output logic             hardware_gate_input
);
  // One step per command; passing a limit wraps and pulses one cycle.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_value     <= 32'h0000_0000;
      count_overflow  <= 1'b0;
      count_underflow <= 1'b0;
    end else begin
      count_overflow  <= up && ($signed(count_value) == hi);
      count_underflow <= down && ($signed(count_value) == lo);
      if (load)
        count_value <= load_value;
      else if (up)
        count_value <= ($signed(count_value) == hi) ? lo : count_value + 1;
      else if (down)
        count_value <= ($signed(count_value) == lo) ? hi : count_value - 1;
    end
  end
  // The gate pin is push-pull, so it simply mirrors the command.
  assign hardware_gate_input = gate_cmd;
endmodule : field_encoder_model

// file: tb/counter_compare_output_irq_tb_top.sv
// Bench for the compare, output and interrupt stage.
// Assumes a 10 MHz clock and a pulse step shortened to 10 cycles.
`timescale 1ns/10ps
module counter_compare_output_irq_tb_top;
  import counter_compare_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] v;} row_type;
  logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, ld = 0, up = 0, dn = 0;
  logic gate = 0, hreadyout, hresp, ovf, unf, gin, chan, flag, cen, irq;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, cnt, lv = 0, q;
  logic [4:0] pir;
  int num_errors = 0, compares = 0, n;
  bit f;
  row_type rows[9] = '{'{8'h00, 32'h0000_0500}, '{8'h04, 0}, '{8'h08, 0},
    '{8'h0c, 0}, '{8'h10, 0}, '{8'h14, 0}, '{8'h18, 0}, '{8'h1c, 0},
    '{8'h20, 0}};
  // Clock of 100 ns period.
  always #50 clock = ~clock;
  counter_compare_output_irq #(.pulse_step_cycles(10)) dut_u (
    .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .count_value(cnt), .count_overflow(ovf),
    .count_underflow(unf), .hardware_gate_input(gin),
    .channel_output(chan), .compare_status_flag(flag),
    .count_enable(cen), .process_irq_pulse(pir), .irq(irq));
  field_encoder_model fe_u (.clock(clock), .nrst(nrst), .load(ld),
    .load_value(lv), .up(up), .down(dn), .gate_cmd(gate),
    .count_value(cnt), .count_overflow(ovf), .count_underflow(unf),
    .hardware_gate_input(gin));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Prints the verdict and stops the run.
  task test_done;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Compares one value and counts a mismatch.
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Waits a bounded number of edges for hready; gives up at the bound.
  task hwait;
    n = 0;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin num_errors++; test_done; end
  endtask : hwait
  // One single word transfer; read data is taken at the data phase edge.
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    hwait;
    htrans <= 2'h0; hsel <= 0; hwdata <= d;
    hwait;
    q = hrdata;
  endtask : bus
  // Sets the count after an edge, then lets it take effect.
  task set(input logic [31:0] v);
    ld <= 1; lv <= v; @(posedge clock); ld <= 0; repeat (3) @(posedge clock);
  endtask : set
  // Waits up to lim edges for bit s of {output, interrupt pulses}.
  task wfor(input int s, input int lim);
    f = 0;
    for (int i = 0; i < lim && !f; i++) begin
      @(posedge clock); f = ({chan, pir} >> s) & 1;
    end
  endtask : wfor
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    foreach (rows[i]) begin
      bus(rows[i].a, 0, 0); chk(q, rows[i].v, "rst");
    end
    chk({hreadyout, hresp}, 2'h2, "okay");
    $display("test reset values done");
    bus(8'h04, 1, 10); bus(8'h10, 1, 32'h1f); bus(8'h18, 1, 32'h04);
    bus(8'h00, 1, 32'h0000_0580); repeat (2) @(posedge clock);
    chk({chan, flag}, 2'h2, "none manual");
    bus(8'h00, 1, 32'h0000_0521); set(5); chk(flag, 0, "below");
    ld <= 1; lv <= 10; @(posedge clock); ld <= 0; wfor(2, 5);
    chk(f, 1, "cmp irq");
    @(posedge clock); chk({chan, flag, irq}, 3'h7, "at value");
    set(3); chk(flag, 0, "released");
    bus(8'h14, 1, 32'h04); bus(8'h14, 0, 0); chk(q, 0, "w1c");
    chk(irq, 0, "irq low");
    $display("test comparator done");
    bus(8'h0c, 1, 2); bus(8'h00, 1, 32'h0000_052a); set(9);
    up <= 1; @(posedge clock); up <= 0; wfor(5, 5);
    chk(f, 1, "pulse start");
    for (int i = 0; i < 60 && chan === 1'b1; i++) begin
      @(posedge clock); n = i + 1; dn <= (i == 4); up <= (i == 5);
    end
    chk(n, 20, "pulse len");
    set(11); dn <= 1; @(posedge clock); dn <= 0; wfor(5, 30);
    chk(f, 0, "wrong dir");
    $display("test pulse done");
    bus(8'h0c, 1, 0); bus(8'h00, 1, 32'h0000_0522); set(9); set(10);
    chk(chan, 1, "len0 held");
    set(12); chk(chan, 0, "len0 end");
    set(100); up <= 1; @(posedge clock); up <= 0; wfor(3, 5);
    chk(f, 1, "ovf");
    set(-100); dn <= 1; @(posedge clock); dn <= 0; wfor(4, 5);
    chk(f, 1, "unf");
    $display("test limits done");
    bus(8'h00, 1, 32'h0000_0660); gate <= 1; repeat (10) @(posedge clock);
    gate <= 0; wfor(0, 60); chk(f, 0, "glitch");
    gate <= 1; wfor(0, 80); chk(f, 1, "gate open");
    repeat (3) @(posedge clock); chk(cen, 1, "count en");
    gate <= 0; wfor(1, 80); chk(f, 1, "gate close");
    chk(cen, 0, "count shut");
    bus(8'h00, 1, 32'h0000_0640); gate <= 1; wfor(0, 80);
    chk(f, 0, "sw closed");
    $display("test gate done");
    // Less-or-equal comparator with a hysteresis band, then band off.
    bus(8'h08, 1, 3); bus(8'h00, 1, 32'h0000_0525);
    set(10); chk(flag, 1, "le set");
    set(12); chk(flag, 1, "hyst hold");
    set(14); chk(flag, 0, "hyst release");
    bus(8'h08, 1, 1); set(10); set(11);
    chk(flag, 0, "hyst off");
    // Pulse only when reaching the value while counting down.
    bus(8'h0c, 1, 1); bus(8'h00, 1, 32'h0000_0532);
    dn <= 1; @(posedge clock); dn <= 0; wfor(5, 5);
    chk(f, 1, "down dir");
    $display("test hysteresis done");
    // Reset in mid-run, with a pulse still in progress.
    nrst <= 0; repeat (2) @(posedge clock); nrst <= 1; @(posedge clock);
    chk({chan, irq, cen}, 0, "mid reset");
    bus(8'h0c, 0, 0); chk(q, 0, "len reset");
    bus(8'h10, 0, 0); chk(q, 0, "irq off");
    $display("test mid reset done");
    test_done;
  end
endmodule : counter_compare_output_irq_tb_top
